// file: core/tmu_top.sv
// tmu_top: counter, wrap limit with holding buffer, config and six channels behind a simple register port.
// assumes a bus master with one-cycle strobes; tally reads answer two cycles later.
`timescale 1ns/1ps
module tmu_top
  import tmu_pkg::*;
#(
  parameter int NCH = TMU_NCH
)(
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              ce_i,
  input  wire logic [7:0]        addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [31:0]       rdata_o,
  output logic                   rvalid_o,
  input  wire logic              debug_i,
  input  wire logic              ext_clk_i,
  input  wire logic [NCH-1:0]    ch_pin_i,
  output logic      [NCH-1:0]    ch_out_o,
  output logic                   wrap_flag_o
);
  typedef struct packed {
    logic [15:0] count;
    logic        down;
    logic [15:0] limit;
    logic [15:0] limit_buf;
    logic        buf_full;
    logic        wrap;
    logic        center;
    logic [1:0]  csrc;
    logic        dbg_run;
    logic        ext_q;
    logic        tick;
    logic        reload;
    logic [31:0] rdata;
    logic        rvalid;
    logic [1:0]  twait;
    logic [NCH-1:0][5:0] chctl;
    logic [NCH-1:0][15:0] chcmp;
  } tmu_st_t;
  tmu_st_t s_q, s_d;
  tmu_ch_if cif ();
  logic [NCH-1:0]       ch_evt;
  logic [NCH-1:0][15:0] ch_cap;
  logic [NCH-1:0]       ch_out;
  logic                 adv;
  logic                 at_lim;
  logic [7:0]           choff;
  logic [31:0]          rd_mux;
  logic                 tally_rd;
  int                   ci;
  assign cif.count  = s_q.count;
  assign cif.tick   = s_q.tick;
  assign cif.down   = s_q.down;
  assign cif.reload = s_q.reload;
  assign cif.center = s_q.center;
  // one decoder per channel, all fed from the same registered count and tick
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : gen_ch
      tmu_channel u_ch (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .en_i    (ce_i),
        .cif     (cif),
        .mode_i  (s_q.chctl[g][3:2]),
        .edge_i  (s_q.chctl[g][1:0]),
        .cmp_i   (s_q.chcmp[g]),
        .pin_i   (ch_pin_i[g]),
        .out_o   (ch_out[g]),
        .cap_o   (ch_cap[g]),
        .event_o (ch_evt[g])
      );
    end
  endgenerate
  always_comb
  begin
    s_d      = s_q;
    ci       = 0;
    choff    = 8'h00;
    rd_mux   = 32'h0000_0000;
    tally_rd = 1'b0;
    s_d.ext_q  = ext_clk_i;
    s_d.tick   = 1'b0;
    s_d.reload = 1'b0;
    s_d.rvalid = 1'b0;
    // count source and debug freeze
    adv = ((s_q.csrc == TMU_SRC_CLK) || ((s_q.csrc == TMU_SRC_EXT) && ext_clk_i && !s_q.ext_q))
          && (!debug_i || s_q.dbg_run);
    at_lim = s_q.count == s_q.limit;
    if (adv)
    begin
      s_d.tick = 1'b1;
      if (s_q.center)
      begin
        // up-down reverses at limit and at zero
        if (!s_q.down && at_lim)
        begin
          s_d.down  = 1'b1;
          s_d.count = s_q.count - 16'h0001;
        end
        else if (s_q.down && s_q.count == 16'h0000)
        begin
          s_d.down   = 1'b0;
          s_d.count  = 16'h0001;
          s_d.reload = 1'b1;
        end
        else
          s_d.count = s_q.down ? s_q.count - 16'h0001 : s_q.count + 16'h0001;
      end
      else if (at_lim)
      begin
        s_d.count  = TMU_TALLY_RST;
        s_d.reload = 1'b1;
      end
      else
        s_d.count = s_q.count + 16'h0001;
      if (at_lim && !s_q.down)
        s_d.wrap = 1'b1;
    end

    // buffered limit applies at the reload point or while stopped
    if (s_q.buf_full && (s_d.reload || s_q.csrc == TMU_SRC_STOP))
    begin
      s_d.limit    = s_q.limit_buf;
      s_d.buf_full = 1'b0;
    end

    // register writes; a tally write overrides counting in the same cycle
    if (wr_i)
    begin
      if (addr_i == TMU_ADDR_CFG)
      begin
        if (wdata_i[TMU_CFG_WRAP] && !(adv && at_lim && !s_q.down))
          s_d.wrap = 1'b0;
        if (s_q.csrc == TMU_SRC_STOP)
          s_d.center = wdata_i[TMU_CFG_CAS];
        s_d.csrc    = wdata_i[TMU_CFG_CSRC +: 2];
        s_d.dbg_run = wdata_i[TMU_CFG_DBGRN];
      end
      else if (addr_i == TMU_ADDR_TALLY)
      begin
        s_d.count = TMU_TALLY_RST;
        s_d.down  = 1'b0;
      end
      else if (addr_i == TMU_ADDR_LIMIT)
      begin
        if (!s_q.buf_full)
        begin
          s_d.limit_buf = wdata_i[15:0];
          s_d.buf_full  = 1'b1;
        end
      end
      else
      begin
        for (ci = 0; ci < NCH; ci++)
        begin
          choff = TMU_ADDR_CH0 + TMU_CH_STRIDE * 8'(ci);
          if (addr_i == choff)
            s_d.chctl[ci] = {2'h0, wdata_i[5:2]};
          else if (addr_i == choff + 8'h04)
            s_d.chcmp[ci] = wdata_i[15:0];
        end
      end
    end

    // non-tally reads answer next cycle from a registered mux; reserved bits stay zero
    if (rd_i)
    begin
      if (addr_i == TMU_ADDR_CFG)
        rd_mux = {23'h0, s_q.dbg_run, s_q.wrap, 1'b0, s_q.center, s_q.csrc, 3'h0};
      else if (addr_i == TMU_ADDR_TALLY)
        tally_rd = 1'b1;
      else if (addr_i == TMU_ADDR_LIMIT)
        rd_mux = {16'h0000, s_q.limit};
      else
      begin
        for (ci = 0; ci < NCH; ci++)
        begin
          choff = TMU_ADDR_CH0 + TMU_CH_STRIDE * 8'(ci);
          // bit 8 is a constant 1 acknowledge; mode bits read back as seen by the channel
          if (addr_i == choff)
            rd_mux = {23'h0, 1'b1, ch_evt[ci], 1'b0, s_q.chctl[ci][3:0], 2'h0};
          else if (addr_i == choff + 8'h04)
            rd_mux = {16'h0000, (s_q.chctl[ci][3:2] == 2'h0) ? ch_cap[ci] : s_q.chcmp[ci]};
        end
      end
      if (!tally_rd)
      begin
        s_d.rdata  = rd_mux;
        s_d.rvalid = 1'b1;
      end
    end

    // tally read answers two cycles late, counted down here
    if (tally_rd)
      s_d.twait = 2'(TMU_TALLY_WAIT);
    else if (s_q.twait != 2'h0)
    begin
      s_d.twait = s_q.twait - 2'h1;
      if (s_q.twait == 2'h1)
      begin
        s_d.rdata  = {16'h0000, s_q.count};
        s_d.rvalid = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_q       <= '0;
      s_q.limit <= TMU_LIMIT_RST;
      s_q.count <= TMU_TALLY_RST;
    end
    else if (ce_i)
      s_q <= s_d;
  end

  // channel outputs are registered in the channel, so they come straight from flops
  assign ch_out_o    = ch_out;
  assign rdata_o     = s_q.rdata;
  assign rvalid_o    = s_q.rvalid;
  assign wrap_flag_o = s_q.wrap;

  chk_tally_wr: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && wr_i && addr_i == TMU_ADDR_TALLY) |=> (s_q.count == 16'h0000))
    else $error("tally write did not clear counter");
  chk_dbg_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && debug_i && !s_q.dbg_run && !wr_i) |=> $stable(s_q.count))
    else $error("counter moved in debug");
  chk_tally_lat: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && rd_i && addr_i == TMU_ADDR_TALLY) ##1 ce_i ##1 ce_i |=> rvalid_o && rdata_o[31:16] == 16'h0000)
    else $error("tally read not answered two cycles late");
  chk_wrap_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && adv && at_lim && !s_q.down) |=> wrap_flag_o)
    else $error("wrap flag not set at limit");
  chk_lim_drop: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && wr_i && addr_i == TMU_ADDR_LIMIT && s_q.buf_full) |=> $stable(s_q.limit_buf))
    else $error("limit write accepted while buffer pending");
  chk_up_wrap: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && adv && at_lim && !s_q.center && !wr_i) |=> (s_q.count == 16'h0000))
    else $error("counter did not return to zero");
  chk_cas_lock: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && s_q.csrc != TMU_SRC_STOP) |=> $stable(s_q.center))
    else $error("center select changed while running");
  chk_src_stop: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && s_q.csrc == TMU_SRC_STOP && !wr_i) |=> $stable(s_q.count))
    else $error("counter moved while stopped");

  // bus timing, limit buffer, wrap flag, count source and count direction checks
  chk_plain_lat: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && rd_i && addr_i != TMU_ADDR_TALLY) |=> rvalid_o)
    else $error("plain read not answered next cycle");

  chk_tally_gap: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && rd_i && addr_i == TMU_ADDR_TALLY && s_q.twait == 2'h0) |=> !rvalid_o)
    else $error("tally read answered without wait states");

  chk_lim_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && wr_i && addr_i == TMU_ADDR_LIMIT && !s_q.buf_full)
    |=> s_q.buf_full && (s_q.limit_buf == $past(wdata_i[15:0])))
    else $error("limit write not buffered");

  chk_lim_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && s_q.buf_full && s_q.csrc != TMU_SRC_STOP && !s_d.reload) |=> $stable(s_q.limit))
    else $error("active limit changed before update point");

  chk_lim_rsv: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && rd_i && addr_i == TMU_ADDR_LIMIT) |=> (rdata_o[31:16] == 16'h0000))
    else $error("limit read upper half not zero");

  chk_wrap_keep: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && s_q.wrap && !(wr_i && addr_i == TMU_ADDR_CFG && wdata_i[TMU_CFG_WRAP])) |=> wrap_flag_o)
    else $error("wrap flag lost without a clear");

  chk_ext_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && s_q.csrc == TMU_SRC_EXT && !(ext_clk_i && !s_q.ext_q) && !wr_i) |=> $stable(s_q.count))
    else $error("counter moved without external edge");

  chk_clk_tick: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && s_q.csrc == TMU_SRC_CLK && !debug_i) |=> s_q.tick)
    else $error("counter missed a clock");

  chk_dbg_run: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && debug_i && s_q.dbg_run && s_q.csrc == TMU_SRC_CLK) |=> s_q.tick)
    else $error("debug-run did not keep counting");

  chk_up_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && adv && !s_q.center && !at_lim && !wr_i) |=> (s_q.count == $past(s_q.count) + 16'h0001))
    else $error("up count did not step by one");

  chk_ctr_turn: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && adv && s_q.center && !s_q.down && at_lim && !wr_i) |=> s_q.down)
    else $error("up-down count did not turn at limit");

  chk_ctr_bottom: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && adv && s_q.center && s_q.down && s_q.count == 16'h0000 && !wr_i) |=> !s_q.down && s_q.reload)
    else $error("up-down count did not turn at zero");
endmodule : tmu_top

// file: core/tmu_pkg.sv
// tmu_pkg: register map, field layout and mode encodings of the timer unit counter and channels.
// assumes a single 25 MHz clock domain shared by bus and counter logic.
// Notes on behaviour
// - reset forces the counter to zero.
// - any write to the tally register clears the counter, data ignored.
// - debug active halts counting unless the debug-run setting is on.
// - a tally read answers two extra cycles later than other reads.
// - counter and limit sit in bits 15..0; bits 31..16 read zero.
// - counter at limit then advancing sets the wrap flag.
// - limit writes land in a holding buffer, applied at the update point.
// - further limit writes are dropped while the buffer is still pending.
// - disable a channel and await acknowledge before changing its mode.
// - mode 00/edge 00 disabled; mode 01/edge 00 software compare, no pin.
// - up-count mode 00 captures on rising, falling or both edges.
// - up-count mode 01 toggles, clears or sets output on match.
// - up-count mode 10 edge PWM; edge 10 high-true, X1 low-true.
// - up-count mode 11 pulses output low (10) or high (01) on match.
// - center mode 10: edge 10 clears on up match, sets on down match.
// - center select chooses up or up-down; writable only while stopped.
// - clock source 00 stop, 01 every clock, 10 external rising edge, 11 reserved.
package tmu_pkg;
  localparam logic [7:0]  TMU_ADDR_CFG   = 8'h00;
  localparam logic [7:0]  TMU_ADDR_TALLY = 8'h04;
  localparam logic [7:0]  TMU_ADDR_LIMIT = 8'h08;
  localparam logic [7:0]  TMU_ADDR_CH0   = 8'h0C;
  localparam logic [7:0]  TMU_CH_STRIDE  = 8'h08;
  localparam int          TMU_NCH        = 6;
  localparam int          TMU_TALLY_WAIT = 2;
  localparam logic [15:0] TMU_TALLY_RST  = 16'h0000;
  localparam logic [15:0] TMU_LIMIT_RST  = 16'hFFFF;
  // cfg register fields
  localparam int TMU_CFG_WRAP  = 7;
  localparam int TMU_CFG_CAS   = 5;
  localparam int TMU_CFG_CSRC  = 3;
  localparam int TMU_CFG_DBGRN = 8;
  // channel control fields
  localparam int TMU_CH_MODE = 4;
  localparam int TMU_CH_EDGE = 2;
  localparam int TMU_CH_ACK  = 8;
  localparam logic [1:0] TMU_SRC_STOP = 2'h0;
  localparam logic [1:0] TMU_SRC_CLK  = 2'h1;
  localparam logic [1:0] TMU_SRC_EXT  = 2'h2;
  typedef enum logic [1:0] {TMU_M_CAP, TMU_M_CMP, TMU_M_PWM, TMU_M_PULSE} tmu_mode_t;
endpackage : tmu_pkg

// file: core/tmu_ch_if.sv
// tmu_ch_if: counter events shared from the counter core to each channel.
// assumes all members are driven in the clk_i domain.
`timescale 1ns/1ps
interface tmu_ch_if;
  logic [15:0] count;
  logic        tick;
  logic        down;
  logic        reload;
  logic        center;
  modport core (output count, tick, down, reload, center);
  modport chan (input  count, tick, down, reload, center);
endinterface : tmu_ch_if

// file: core/tmu_channel.sv
// tmu_channel: mode/edge decoder and output or capture logic of one channel.
// assumes the compare value and the pin input are synchronous to clk_i.
`timescale 1ns/1ps
module tmu_channel
  import tmu_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        en_i,
  tmu_ch_if.chan           cif,
  input  wire logic [1:0]  mode_i,
  input  wire logic [1:0]  edge_i,
  input  wire logic [15:0] cmp_i,
  input  wire logic        pin_i,
  output logic             out_o,
  output logic [15:0]      cap_o,
  output logic             event_o
);
  typedef struct packed {
    logic        out;
    logic        pin;
    logic [15:0] cap;
    logic        evt;
  } tmu_ch_st_t;
  tmu_ch_st_t s_q, s_d;
  logic match, rise, fall, off;
  always_comb
  begin
    s_d   = s_q;
    match = cif.tick && (cif.count == cmp_i);
    rise  = pin_i && !s_q.pin;
    fall  = !pin_i && s_q.pin;
    off   = (edge_i == 2'h0);
    s_d.pin = pin_i;
    s_d.evt = 1'b0;
    if (off)
    begin
      // disabled or software compare: pin idle, compare only flags
      s_d.evt = (mode_i == 2'h1) && match;
    end
    else if (cif.center)
    begin
      if (mode_i == 2'h2 && match)
      begin
        // center pwm: edge 10 high-true, 01 low-true
        s_d.out = cif.down ? edge_i[1] : edge_i[0];
        s_d.evt = 1'b1;
      end
    end
    else
    begin
      case (tmu_mode_t'(mode_i))
        TMU_M_CAP:
        if ((rise && edge_i[0]) || (fall && edge_i[1]))
        begin
          s_d.cap = cif.count;
          s_d.evt = 1'b1;
        end
        TMU_M_CMP:
        if (match)
        begin
          s_d.out = (edge_i == 2'h1) ? !s_q.out : edge_i[0];
          s_d.evt = 1'b1;
        end
        TMU_M_PWM:
        begin
          if (cif.reload)
            s_d.out = !edge_i[0];
          if (match)
          begin
            s_d.out = edge_i[0];
            s_d.evt = 1'b1;
          end
        end
        default:
        begin
          // one-tick pulse at match, idle level otherwise
          s_d.out = match ? edge_i[0] : edge_i[1];
          s_d.evt = match;
        end
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      s_q <= '0;
    else if (en_i)
      s_q <= s_d;
  end
  assign out_o   = s_q.out;
  assign cap_o   = s_q.cap;
  assign event_o = s_q.evt;
  chk_cmp_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (en_i && !cif.center && mode_i == 2'h1 && edge_i == 2'h3 && match) |=> out_o)
    else $error("set on match did not drive output high");
  chk_cap_rise: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (en_i && !cif.center && mode_i == 2'h0 && edge_i == 2'h1 && rise) |=> (cap_o == $past(cif.count)) && event_o)
    else $error("rising edge capture lost");
  chk_ctr_pwm: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (en_i && cif.center && mode_i == 2'h2 && edge_i == 2'h2 && match && !cif.down) |=> !out_o)
    else $error("center pwm up match did not clear output");
endmodule : tmu_channel

// file: sim/tb_timer_counter_channel_modes.sv
// tb_timer_counter_channel_modes: self-checking bench for the timer unit top level.
// assumes tmu_top with its single 25 MHz clock and one-cycle register strobes.
`timescale 1ns/1ps
module tb_timer_counter_channel_modes;
  import tmu_pkg::*;
  typedef struct {logic [3:0] me; logic [15:0] cmp; logic cen; int kind; logic lvl;} tmu_row_t;
  localparam logic [31:0] RUN = 32'h0000_0008;
  logic                clk_i     = 1'b0;
  logic                rstn_i    = 1'b0;
  logic                ce_i      = 1'b1;
  logic [7:0]          addr_i    = 8'h00;
  logic [31:0]         wdata_i   = 32'h0000_0000;
  logic                wr_i      = 1'b0;
  logic                rd_i      = 1'b0;
  logic                debug_i   = 1'b0;
  logic                ext_clk_i = 1'b0;
  logic [TMU_NCH-1:0]  ch_pin_i  = '0;
  logic [31:0]         rdata_o;
  logic                rvalid_o;
  logic                wrap_flag_o;
  logic [TMU_NCH-1:0]  ch_out_o;
  int                  error_cnt   = 0;
  int                  check_count = 0;
  logic [31:0]         v1;
  logic [31:0]         v2;
  logic [31:0]         v3;
  logic                s0;
  logic                s1;
  int                  lat;
  int                  ch;
  // kind 0: steady level, 1: output moves both ways, 2: read-back only
  tmu_row_t rows[11] = '{
    '{4'h7, 16'h0004, 1'b0, 0, 1'b1}, '{4'h6, 16'h0004, 1'b0, 0, 1'b0}, '{4'h5, 16'h0004, 1'b0, 1, 1'b0},
    '{4'hA, 16'h00FF, 1'b0, 0, 1'b1}, '{4'h9, 16'h00FF, 1'b0, 0, 1'b0}, '{4'hB, 16'h00FF, 1'b0, 0, 1'b0},
    '{4'hD, 16'h0004, 1'b0, 1, 1'b0}, '{4'hE, 16'h0004, 1'b0, 1, 1'b0}, '{4'h4, 16'h0004, 1'b0, 2, 1'b0},
    '{4'hA, 16'h0002, 1'b1, 1, 1'b0}, '{4'h9, 16'h0002, 1'b1, 1, 1'b0}};

  tmu_top #(.NCH(TMU_NCH)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .debug_i(debug_i),
    .ext_clk_i(ext_clk_i), .ch_pin_i(ch_pin_i), .ch_out_o(ch_out_o), .wrap_flag_o(wrap_flag_o));

  initial
  begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic give_verdict();
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : reg_wr

  // waits for the answer; a count of 8 means it never came
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d, output int n);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    n = 1;
    #1;
    while (rvalid_o !== 1'b1 && n < 8)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    d = rdata_o;
  endtask : reg_rd

  task automatic observe(input int c);
    s0 = 1'b0;
    s1 = 1'b0;
    repeat (40)
    begin
      @(posedge clk_i);
      #1;
      if (ch_out_o[c] === 1'b0) s0 = 1'b1;
      if (ch_out_o[c] === 1'b1) s1 = 1'b1;
    end
  endtask : observe

  initial
  begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    give_verdict();
  end

  initial
  begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    reg_rd(TMU_ADDR_TALLY, v1, lat);
    check(v1, 32'h0000_0000, "tally after reset");
    check(32'(lat), 32'h0000_0003, "tally read latency");
    reg_rd(TMU_ADDR_LIMIT, v1, lat);
    check(v1, 32'h0000_FFFF, "limit after reset");
    check(32'(lat), 32'h0000_0001, "plain read latency");
    reg_rd(8'hFC, v1, lat);
    check(v1, 32'h0000_0000, "unmapped read");
    // debug halt, then debug-run, then normal counting
    debug_i <= 1'b1;
    reg_wr(TMU_ADDR_CFG, RUN);
    reg_rd(TMU_ADDR_TALLY, v1, lat);
    reg_rd(TMU_ADDR_TALLY, v2, lat);
    check(v2, v1, "count moved in debug");
    reg_wr(TMU_ADDR_CFG, 32'h0000_0108);
    reg_rd(TMU_ADDR_TALLY, v1, lat);
    reg_rd(TMU_ADDR_TALLY, v2, lat);
    check(v2, v1 + 32'h4, "debug-run count step");
    debug_i <= 1'b0;
    reg_wr(TMU_ADDR_CFG, RUN);
    reg_rd(TMU_ADDR_TALLY, v1, lat);
    reg_rd(TMU_ADDR_TALLY, v2, lat);
    check(v2, v1 + 32'h4, "count step per clock");
    reg_wr(TMU_ADDR_CFG, 32'h0000_0028);
    reg_rd(TMU_ADDR_CFG, v1, lat);
    check(v1 & 32'h20, 32'h0000_0000, "center select taken while running");
    reg_wr(TMU_ADDR_CFG, 32'h0000_0000);
    reg_wr(TMU_ADDR_TALLY, 32'hFFFF_1234);
    reg_rd(TMU_ADDR_TALLY, v1, lat);
    check(v1, 32'h0000_0000, "tally write clears");
    // external count clock, five rising edges
    reg_wr(TMU_ADDR_CFG, 32'h0000_0010);
    repeat (5)
    begin
      ext_clk_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      ext_clk_i <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
    reg_wr(TMU_ADDR_CFG, 32'h0000_0000);
    reg_rd(TMU_ADDR_TALLY, v1, lat);
    check(v1, 32'h0000_0005, "external edge count");
    repeat (6) @(posedge clk_i);
    reg_rd(TMU_ADDR_TALLY, v2, lat);
    check(v2, v1, "stopped count moved");
    // wrap at a small limit
    reg_wr(TMU_ADDR_TALLY, 32'h0000_0000);
    reg_wr(TMU_ADDR_LIMIT, 32'h0000_0003);
    reg_wr(TMU_ADDR_CFG, 32'h0000_0080);
    #1;
    check(32'(wrap_flag_o), 32'h0, "wrap flag not cleared");
    reg_wr(TMU_ADDR_CFG, RUN);
    #1;
    check(32'(wrap_flag_o), 32'h0, "wrap flag early");
    repeat (10) @(posedge clk_i);
    #1;
    check(32'(wrap_flag_o), 32'h1, "wrap flag missing");
    reg_wr(TMU_ADDR_CFG, 32'h0000_0000);
    reg_rd(TMU_ADDR_TALLY, v1, lat);
    check(32'(v1 <= 32'h3), 32'h1, "count beyond limit");
    reg_rd(TMU_ADDR_CFG, v1, lat);
    check(v1 & 32'h80, 32'h0000_0080, "wrap flag in cfg");
    // buffered limit: second write dropped, first applied at reload
    reg_wr(TMU_ADDR_LIMIT, 32'h0000_00FF);
    reg_wr(TMU_ADDR_TALLY, 32'h0000_0000);
    reg_wr(TMU_ADDR_CFG, RUN);
    repeat (20) @(posedge clk_i);
    reg_wr(TMU_ADDR_LIMIT, 32'hFFFF_0005);
    reg_wr(TMU_ADDR_LIMIT, 32'h0000_0007);
    repeat (300) @(posedge clk_i);
    reg_rd(TMU_ADDR_TALLY, v1, lat);
    check(32'(v1 <= 32'h5), 32'h1, "new limit not in force");
    reg_wr(TMU_ADDR_CFG, 32'h0000_0000);
    reg_rd(TMU_ADDR_LIMIT, v1, lat);
    check(v1, 32'h0000_0005, "limit buffer");
    // channel modes; each change goes through disable first
    reg_wr(TMU_ADDR_LIMIT, 32'h0000_0009);
    foreach (rows[i])
    begin
      ch = i % TMU_NCH;
      reg_wr(TMU_ADDR_CFG, 32'h0000_0000);
      reg_wr(TMU_ADDR_CH0 + 8'(8 * ch), 32'h0000_0000);
      reg_rd(TMU_ADDR_CH0 + 8'(8 * ch), v1, lat);
      check(v1 & 32'h13C, 32'h0000_0100, "channel disable ack");
      reg_wr(TMU_ADDR_CH0 + 8'(8 * ch), {26'h0, rows[i].me, 2'h0});
      reg_wr(TMU_ADDR_CH0 + 8'(8 * ch + 4), {16'h0, rows[i].cmp});
      reg_rd(TMU_ADDR_CH0 + 8'(8 * ch), v1, lat);
      check(v1 & 32'h13C, {24'h1, 2'h0, rows[i].me, 2'h0}, "channel mode read-back");
      reg_wr(TMU_ADDR_CFG, {26'h0, rows[i].cen, 5'h0});
      reg_wr(TMU_ADDR_CFG, {26'h0, rows[i].cen, 5'h0} | RUN);
      observe(ch);
      if (rows[i].kind == 0)
        check(32'(ch_out_o[ch]), 32'(rows[i].lvl), "channel steady level");
      if (rows[i].kind == 1)
        check(32'(s0 & s1), 32'h1, "channel output idle");
    end
    // capture: rising only, falling only, both
    reg_wr(TMU_ADDR_CFG, 32'h0000_0000);
    reg_wr(TMU_ADDR_LIMIT, 32'h0000_FFFF);
    for (int e = 1; e < 4; e++)
    begin
      reg_wr(TMU_ADDR_CH0 + 8'h08, 32'h0000_0000);
      reg_wr(TMU_ADDR_CH0 + 8'h08, 32'(e) << 2);
      reg_wr(TMU_ADDR_CFG, RUN);
      reg_wr(TMU_ADDR_CFG, 32'h0000_0000);
      reg_rd(TMU_ADDR_TALLY, v1, lat);
      @(posedge clk_i);
      ch_pin_i[1] <= 1'b1;
      repeat (4) @(posedge clk_i);
      reg_wr(TMU_ADDR_CFG, RUN);
      reg_wr(TMU_ADDR_CFG, 32'h0000_0000);
      reg_rd(TMU_ADDR_TALLY, v2, lat);
      @(posedge clk_i);
      ch_pin_i[1] <= 1'b0;
      repeat (4) @(posedge clk_i);
      reg_rd(TMU_ADDR_CH0 + 8'h0C, v3, lat);
      check(v3, (e == 1) ? v1 : v2, "captured count");
    end
    give_verdict();
  end
endmodule : tb_timer_counter_channel_modes
